// ### design/pts_codec.sv
/*
  Codec end of the PCM time-slot port: shifts one 8-bit word out and one in per
  frame under independent transmit and receive strobes, with A/B signaling.
  Assumes the link signals are asynchronous to clock and sampled here; the user
  side supplies transmit words through a FIFO and takes received words.
*/
`timescale 1ns/1ps
`default_nettype none
module pts_codec
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Link.
  pts_if.codec link,
  // Transmit words from the coder.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_word,
  // Transmit signaling inputs from line supervision.
  input wire logic sig_a_in,
  input wire logic sig_b_in,
  // Received words to the decoder.
  output logic rx_valid,
  output logic [7:0] rx_word,
  // Received signaling outputs.
  output logic sig_a_out,
  output logic sig_b_out
);
  localparam int W = pts_pkg::WORD_BITS;
  // ==========================================
  // Input synchronisers
  logic [4:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= {link.sclk, link.tx_strobe, link.rx_strobe, link.tx_ab_sel, link.rx_ab_sel};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic sclk_rise, sclk_fall, txs_rise, rxs_rise, sig_a_s, sig_b_s, pin_s;
  logic txsel, rxsel;
  assign sclk_rise = s2_r[4] && !s3_r[4];
  assign sclk_fall = !s2_r[4] && s3_r[4];
  assign txs_rise = s2_r[3] && !s3_r[3];
  assign rxs_rise = s2_r[2] && !s3_r[2];
  assign txsel = s2_r[1];
  assign rxsel = s2_r[0];
  logic [2:0] d1_r, d2_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      d1_r <= '0;
      d2_r <= '0;
    end
    else
    begin
      d1_r <= {sig_a_in, sig_b_in, link.pcm_in};
      d2_r <= d1_r;
    end
  end
  assign sig_a_s = d2_r[2];
  assign sig_b_s = d2_r[1];
  assign pin_s = d2_r[0];
  // ==========================================
  // Transmit word buffer
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_word;
  pts_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo
  (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );
  // ==========================================
  // Transmit section
  logic [3:0] tcnt_r, tcnt_nxt;
  logic [7:0] tsh_r, tsh_nxt;
  logic out_r, out_nxt, oe_r, oe_nxt;
  logic tsel_r, tsel_nxt, tcap_r, tcap_nxt, tpend_r, tpend_nxt;
  logic [7:0] tword;
  assign fifo_pop = txs_rise && fifo_valid;
  always_comb
  begin
    tcnt_nxt = tcnt_r;
    tsh_nxt = tsh_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    tsel_nxt = tsel_r;
    tcap_nxt = tcap_r;
    tpend_nxt = tpend_r;
    tword = fifo_valid ? fifo_word : 8'hFF;
    if (txs_rise)
    begin
      // Select is looked at only on strobe edges, so one shared line serves all slots.
      tpend_nxt = 1'b0;
      if (txsel != tsel_r)
      begin
        tsel_nxt = txsel;
        tcap_nxt = txsel ? sig_a_s : sig_b_s;
        tpend_nxt = 1'b1;
      end
      if (tpend_r)
        tword[0] = tcap_r;
      tsh_nxt = tword;
      tcnt_nxt = 4'h0;
      oe_nxt = 1'b1;
      out_nxt = tword[W-1];
    end
    else if (sclk_fall && oe_r && tcnt_r != 4'h0)
    begin
      out_nxt = tsh_r[W-1];
    end
    else if (sclk_rise && oe_r)
    begin
      tsh_nxt = {tsh_r[W-2:0], 1'b0};
      tcnt_nxt = tcnt_r + 4'h1;
      if (tcnt_r == 4'(W - 1))
        oe_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tcnt_r <= '0;
      tsh_r <= '0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      tsel_r <= 1'b0;
      tcap_r <= 1'b0;
      tpend_r <= 1'b0;
    end
    else
    begin
      tcnt_r <= tcnt_nxt;
      tsh_r <= tsh_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      tsel_r <= tsel_nxt;
      tcap_r <= tcap_nxt;
      tpend_r <= tpend_nxt;
    end
  end
  assign link.pcm_out = out_r;
  assign link.pcm_out_oe = oe_r;
  // ==========================================
  // Receive section
  logic [3:0] rcnt_r, rcnt_nxt;
  logic [7:0] rsh_r, rsh_nxt, rword_r, rword_nxt;
  logic rv_r, rv_nxt, rsel_r, rsel_nxt, ra_r, ra_nxt, rb_r, rb_nxt;
  logic rgrab_r, rgrab_nxt;
  always_comb
  begin
    rcnt_nxt = rcnt_r;
    rsh_nxt = rsh_r;
    rword_nxt = rword_r;
    rv_nxt = 1'b0;
    rsel_nxt = rsel_r;
    ra_nxt = ra_r;
    rb_nxt = rb_r;
    rgrab_nxt = rgrab_r;
    if (rxs_rise)
    begin
      rcnt_nxt = 4'h0;
      if (rxsel != rsel_r)
      begin
        rsel_nxt = rxsel;
        rgrab_nxt = 1'b1;
      end
    end
    else if (sclk_rise && rcnt_r != 4'(W))
    begin
      rsh_nxt = {rsh_r[W-2:0], pin_s};
      rcnt_nxt = rcnt_r + 4'h1;
      if (rcnt_r == 4'(W - 1))
      begin
        rword_nxt = {rsh_r[W-2:0], pin_s};
        rv_nxt = 1'b1;
        if (rgrab_r)
        begin
          // Latched in the frame of the select edge; held until the next one.
          if (rsel_r)
            ra_nxt = pin_s;
          else
            rb_nxt = pin_s;
          rgrab_nxt = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rcnt_r <= 4'(W);
      rsh_r <= '0;
      rword_r <= '0;
      rv_r <= 1'b0;
      rsel_r <= 1'b0;
      ra_r <= 1'b0;
      rb_r <= 1'b0;
      rgrab_r <= 1'b0;
    end
    else
    begin
      rcnt_r <= rcnt_nxt;
      rsh_r <= rsh_nxt;
      rword_r <= rword_nxt;
      rv_r <= rv_nxt;
      rsel_r <= rsel_nxt;
      ra_r <= ra_nxt;
      rb_r <= rb_nxt;
      rgrab_r <= rgrab_nxt;
    end
  end
  assign rx_valid = rv_r;
  assign rx_word = rword_r;
  assign sig_a_out = ra_r;
  assign sig_b_out = rb_r;
endmodule
`default_nettype wire

// ### design/pts_pkg.sv
/*
  Shared constants for the PCM time-slot port with A/B signaling: the codec end
  (pts_codec) and the timing/supervision end (pts_ctrl), joined by pts_if.
  Assumes one 100 MHz system clock shared by both ends; the shift clock and the
  strobes are link signals that every receiver samples through two flip-flops.
*/
// Notes on behaviour
// - Receive A/B latched in same frame as select edge.
// - Controller raises receive select frame 6, drops frame 12.
// - Carrier frame: 24 slots of 8 bits plus one.
// - Alternate frame: 30 voice plus 2 service slots.
// - Transmit and receive each follow their own strobe.
// - Timing needs shift clock, frame and superframe pulses.
// - Strobes of any width work if high for at least one system clock; only the rise is used.
// - Single line: system and shift clocks locked to sync.
// - One sync signal may serve as both strobes.
// - Transmit select rise samples A, fall samples B.
// - Captured bit sent in the following frame.
// - Signaling bit replaces word LSB every sixth frame.
// - Strobe rise resets bit count; output released after eight.
package pts_pkg;
  localparam int WORD_BITS = 8;
  localparam int SLOTS_T1 = 24;
  localparam int FRAME_BITS_T1 = SLOTS_T1 * WORD_BITS + 1;
  localparam int SLOTS_E1 = 32;
  localparam int FRAME_BITS_E1 = SLOTS_E1 * WORD_BITS;
  localparam int SUPERFRAME = 12;
  localparam int SIG_FRAME_A = 6;
  localparam int SIG_FRAME_B = 12;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
endpackage

// ### design/pts_if.sv
/*
  Link between the codec end and the timing end of the PCM port.
  Assumes both ends share the system clock; the bench may watch every signal.
*/
`timescale 1ns/1ps
`default_nettype none
interface pts_if;
  logic sclk;
  logic tx_strobe;
  logic rx_strobe;
  logic tx_ab_sel;
  logic rx_ab_sel;
  logic pcm_out;
  logic pcm_out_oe;
  logic pcm_in;
  modport codec
  (
    input sclk, tx_strobe, rx_strobe, tx_ab_sel, rx_ab_sel, pcm_in,
    output pcm_out, pcm_out_oe
  );
  modport ctrl
  (
    output sclk, tx_strobe, rx_strobe, tx_ab_sel, rx_ab_sel, pcm_in,
    input pcm_out, pcm_out_oe
  );
endinterface
`default_nettype wire

// ### design/pts_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pts_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("pts_fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;
  // ==========================================
  // Pointers
  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r[AW-1:0]];
  always_comb
  begin
    wr_nxt = push ? wr_r + (AW+1)'(1) : wr_r;
    rd_nxt = pop ? rd_r + (AW+1)'(1) : rd_r;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end
  // Storage has no reset; only written entries are ever read.
  always_ff @(posedge clock)
  begin
    if (push)
      mem_r[wr_r[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ### design/pts_ctrl.sv
/*
  Timing end of the PCM port: divides the system clock into the shift clock,
  counts bits, frames and superframes, and drives strobes, A/B selects and the
  receive data for one chosen slot.
  Assumes the codec end answers on pcm_out while pcm_out_oe is high.
*/
`timescale 1ns/1ps
`default_nettype none
module pts_ctrl
#(
  parameter int SLOTS = pts_pkg::SLOTS_T1,
  parameter bit FRAMING_BIT = 1'b1,
  parameter int TX_SLOT = 0,
  parameter int RX_SLOT = 0
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Link.
  pts_if.ctrl link,
  // Word to send to the codec in its receive slot.
  input wire logic [7:0] rx_send_word,
  // Word taken from the codec in its transmit slot.
  output logic tx_got_valid,
  output logic [7:0] tx_got_word,
  // Frame markers.
  output logic frame_pulse,
  output logic superframe_pulse
);
  localparam int W = pts_pkg::WORD_BITS;
  localparam int FBITS = SLOTS * W + (FRAMING_BIT ? 1 : 0);
  initial
  begin
    if (TX_SLOT >= SLOTS || RX_SLOT >= SLOTS || SLOTS < 1 || SLOTS > 32)
      $error("pts_ctrl slot settings out of range");
  end
  localparam int OFS = FRAMING_BIT ? 1 : 0;
  logic [7:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt;
  logic [8:0] bit_r, bit_nxt;
  logic [3:0] frm_r, frm_nxt;
  logic [7:0] tsh_r, tsh_nxt, got_r, got_nxt;
  logic gv_r, gv_nxt, pin_r, pin_nxt;
  logic [1:0] o1_r, o2_r;
  logic fall;
  assign fall = (div_r == 8'(pts_pkg::SCLK_HALF_CYC - 1)) && sclk_r;
  // ==========================================
  // Shift clock, bit and frame counters
  always_comb
  begin
    div_nxt = div_r + 8'h1;
    sclk_nxt = sclk_r;
    bit_nxt = bit_r;
    frm_nxt = frm_r;
    tsh_nxt = tsh_r;
    got_nxt = got_r;
    gv_nxt = 1'b0;
    pin_nxt = pin_r;
    if (div_r == 8'(pts_pkg::SCLK_HALF_CYC - 1))
    begin
      div_nxt = 8'h0;
      sclk_nxt = !sclk_r;
      // Taken on the shift clock's fall: the codec's answer to a fall comes
      // back through two synchronisers on each side, too late for the next rise.
      if (sclk_r && o2_r[0])
        got_nxt = {got_r[6:0], o2_r[1]};
      if (sclk_r && o2_r[0] && bit_r == 9'(OFS + TX_SLOT * W + W - 1))
        gv_nxt = 1'b1;
      if (sclk_r)
      begin
        bit_nxt = (bit_r == 9'(FBITS - 1)) ? 9'h0 : bit_r + 9'h1;
        if (bit_r == 9'(FBITS - 1))
          frm_nxt = (frm_r == 4'(pts_pkg::SUPERFRAME)) ? 4'h1 : frm_r + 4'h1;
        if (bit_nxt == 9'(OFS + RX_SLOT * W))
          tsh_nxt = rx_send_word;
        else
          tsh_nxt = {tsh_r[6:0], 1'b0};
        pin_nxt = (bit_nxt == 9'(OFS + RX_SLOT * W)) ? rx_send_word[7] : tsh_r[6];
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r <= '0;
      sclk_r <= 1'b0;
      bit_r <= '0;
      frm_r <= 4'h1;
      tsh_r <= '0;
      got_r <= '0;
      gv_r <= 1'b0;
      pin_r <= 1'b0;
      o1_r <= '0;
      o2_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      bit_r <= bit_nxt;
      frm_r <= frm_nxt;
      tsh_r <= tsh_nxt;
      got_r <= got_nxt;
      gv_r <= gv_nxt;
      pin_r <= pin_nxt;
      o1_r <= {link.pcm_out, link.pcm_out_oe};
      o2_r <= o1_r;
    end
  end
  // ==========================================
  // Strobes and selects
  logic in_tx, in_rx;
  assign in_tx = bit_r >= 9'(OFS + TX_SLOT * W) && bit_r < 9'(OFS + TX_SLOT * W + 2);
  assign in_rx = bit_r >= 9'(OFS + RX_SLOT * W) && bit_r < 9'(OFS + RX_SLOT * W + 2);
  assign link.sclk = sclk_r;
  assign link.tx_strobe = in_tx;
  assign link.rx_strobe = in_rx;
  // Transmit select leads by one frame since the codec sends a frame later.
  assign link.tx_ab_sel = frm_r >= 4'(pts_pkg::SIG_FRAME_A - 1) &&
    frm_r < 4'(pts_pkg::SIG_FRAME_B - 1);
  assign link.rx_ab_sel = frm_r >= 4'(pts_pkg::SIG_FRAME_A) &&
    frm_r < 4'(pts_pkg::SIG_FRAME_B);
  assign link.pcm_in = pin_r;
  assign tx_got_valid = gv_r;
  assign tx_got_word = got_r;
  assign frame_pulse = bit_r == 9'h0 && div_r == 8'h0 && !sclk_r;
  assign superframe_pulse = frame_pulse && frm_r == 4'h1;
endmodule
`default_nettype wire

// ### tb/pts_checker.sv
/*
  Concurrent checks on the link between the codec end and the timing end.
  Assumes the bench hands over the link signals and the shared system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pts_checker
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Link.
  input wire logic sclk,
  input wire logic tx_strobe,
  input wire logic rx_strobe,
  input wire logic tx_ab_sel,
  input wire logic rx_ab_sel,
  input wire logic pcm_out_oe
);
  localparam int FRAME_CYC = pts_pkg::FRAME_BITS_T1 * 8;
  logic [3:0] bits_r;
  logic [3:0] bits_nxt;
  logic [11:0] cyc_r;
  logic [11:0] cyc_nxt;
  logic sclk_d_r;
  logic stb_d_r;
  // ==========================================
  // Shift clock rises since the last strobe, and clocks between strobes.
  // Both saturate, so an idle link never wraps into a false count.
  always_comb
  begin
    bits_nxt = bits_r;
    cyc_nxt = cyc_r;
    if (cyc_r != 12'h000 && cyc_r != 12'hFFF)
      cyc_nxt = cyc_r + 12'h001;
    if (tx_strobe && !stb_d_r)
    begin
      bits_nxt = 4'h0;
      cyc_nxt = 12'h001;
    end
    else if (sclk && !sclk_d_r && bits_r != 4'hF)
      bits_nxt = bits_r + 4'h1;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bits_r <= 4'hF;
      cyc_r <= 12'h000;
      sclk_d_r <= 1'b0;
      stb_d_r <= 1'b0;
    end
    else
    begin
      bits_r <= bits_nxt;
      cyc_r <= cyc_nxt;
      sclk_d_r <= sclk;
      stb_d_r <= tx_strobe;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  oe_start_a: assert property ($rose(tx_strobe) |-> ##[1:8] pcm_out_oe)
    else $error("output not enabled after strobe");
  oe_hold_a: assert property (bits_r >= 4'h2 && bits_r <= 4'h6 |-> pcm_out_oe)
    else $error("output dropped inside word");
  oe_release_a: assert property (bits_r >= 4'h9 |-> !pcm_out_oe)
    else $error("output still driven after eight bits");
  rx_quiet_a: assert property ($rose(rx_strobe) |-> !pcm_out_oe [*8])
    else $error("receive strobe enabled the output");
  sclk_period_a: assert property ($rose(sclk) |=> (!$rose(sclk)) [*7] ##1 $rose(sclk))
    else $error("shift clock period wrong");
  sclk_duty_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("shift clock high time wrong");
  frame_len_a: assert property ($rose(tx_strobe) && cyc_r != 12'h000 |-> cyc_r == 12'(FRAME_CYC))
    else $error("frame length wrong");
  strobe_width_a: assert property ($rose(tx_strobe) |-> tx_strobe [*8])
    else $error("strobe too short");
  sel_rise_a: assert property ($rose(rx_ab_sel) |-> tx_ab_sel)
    else $error("receive select rose out of order");
  sel_fall_a: assert property ($fell(rx_ab_sel) |-> !tx_ab_sel)
    else $error("receive select fell out of order");
endmodule
`default_nettype wire

// ### tb/tb_pcm_timeslot_ab_signaling_port.sv
/*
  Self-checking bench: codec and timing ends joined by the link, with a
  queue model of the transmit words and the signaling latches.
  Assumes the package, interface and design modules are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pcm_timeslot_ab_signaling_port;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_word = 8'h00;
  logic sig_a_in = 1'b0;
  logic sig_b_in = 1'b0;
  logic [7:0] rx_send_word = 8'h5A;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_word;
  logic sig_a_out;
  logic sig_b_out;
  logic tx_got_valid;
  logic [7:0] tx_got_word;
  logic frame_pulse;
  logic superframe_pulse;
  int err_total = 0;
  int n_compared = 0;
  int seed = 42;
  int tx_arm = 0;
  int frm_m = 0;
  logic [7:0] txq[$];
  logic [7:0] exp_w;
  logic [7:0] rx_exp = 8'h5A;
  logic tx_sig = 1'b0;
  logic tx_sel_d = 1'b0;
  logic rx_sel_d = 1'b0;
  logic rx_arm = 1'b0;
  logic a_exp = 1'b0;
  logic b_exp = 1'b0;
  always #5 clock = ~clock;
  pts_if i_pts_if();
  pts_codec i_pts_codec (.clock(clock), .rst_b(rst_b), .link(i_pts_if.codec),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .sig_a_in(sig_a_in),
    .sig_b_in(sig_b_in), .rx_valid(rx_valid), .rx_word(rx_word), .sig_a_out(sig_a_out),
    .sig_b_out(sig_b_out));
  // The receive slot differs from the transmit slot so the two strobes stay apart.
  pts_ctrl #(.RX_SLOT(3)) i_pts_ctrl (.clock(clock), .rst_b(rst_b), .link(i_pts_if.ctrl),
    .rx_send_word(rx_send_word), .tx_got_valid(tx_got_valid), .tx_got_word(tx_got_word),
    .frame_pulse(frame_pulse), .superframe_pulse(superframe_pulse));
  pts_checker i_pts_checker (.clock(clock), .rst_b(rst_b), .sclk(i_pts_if.sclk),
    .tx_strobe(i_pts_if.tx_strobe), .rx_strobe(i_pts_if.rx_strobe),
    .tx_ab_sel(i_pts_if.tx_ab_sel), .rx_ab_sel(i_pts_if.rx_ab_sel),
    .pcm_out_oe(i_pts_if.pcm_out_oe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // Model of both directions, updated on every result.
  always @(posedge clock)
  begin
    if (rst_b && frame_pulse === 1'b1)
    begin
      frm_m = (frm_m % pts_pkg::SUPERFRAME) + 1;
      chk(8'(superframe_pulse), 8'(frm_m == 1));
    end
    if (rst_b && i_pts_if.tx_ab_sel !== tx_sel_d)
    begin
      tx_sig = i_pts_if.tx_ab_sel ? sig_a_in : sig_b_in;
      tx_arm = 2;
    end
    tx_sel_d = i_pts_if.tx_ab_sel;
    if (tx_got_valid === 1'b1)
    begin
      exp_w = (txq.size() > 0) ? txq.pop_front() : 8'hFF;
      if (tx_arm == 1)
        exp_w[0] = tx_sig;
      chk(tx_got_word, exp_w);
      if (tx_arm > 0)
        tx_arm--;
      sig_a_in <= 1'($random(seed));
      sig_b_in <= 1'($random(seed));
    end
    if (tx_valid && tx_ready)
      txq.push_back(tx_word);
    if (rst_b && i_pts_if.rx_ab_sel !== rx_sel_d)
      rx_arm = 1'b1;
    rx_sel_d = i_pts_if.rx_ab_sel;
    if (rx_valid === 1'b1)
    begin
      // The latch lands with the word, so the new level is due at once.
      if (rx_arm && rx_sel_d)
        a_exp = rx_exp[0];
      if (rx_arm && !rx_sel_d)
        b_exp = rx_exp[0];
      chk(rx_word, rx_exp);
      chk(8'(sig_a_out), 8'(a_exp));
      chk(8'(sig_b_out), 8'(b_exp));
      rx_arm = 1'b0;
      rx_exp = 8'($random(seed));
      rx_send_word <= rx_exp;
    end
  end
  // Pushes more words than the buffer holds; the surplus must be refused.
  task automatic fill(input int n);
    int k;
    k = 0;
    @(posedge tx_got_valid);
    repeat (n)
    begin
      tx_valid <= 1'b1;
      tx_word <= 8'($random(seed));
      do
      begin
        @(posedge clock);
        if (!tx_ready)
          k++;
      end while (!tx_ready);
    end
    tx_valid <= 1'b0;
    chk(8'(k > 0), 8'h01);
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    fill(6);
    $display("fill and refusal test done");
    repeat (8) @(posedge frame_pulse);
    $display("drain test done");
    repeat (26) @(posedge frame_pulse);
    $display("signaling test done");
    end_sim();
  end
  initial
  begin
    #900000;
    err_total++;
    $display("[ERR] %0t ns: run did not finish", $time);
    end_sim();
  end
endmodule
`default_nettype wire
